// ---- rtl/cfs_top.sv ----
// configuration space register bank, sector decode and flash command control
// assumes bus strobes from logic on ref_clk; port pins are asynchronous
`timescale 1ns/1ps
`include "cfs_regs.svh"
module cfs_top (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         reset,
  // processor bus, same clock
  input  wire cfs_pkg::cfs_bus_s            bus,
  output logic      [7:0]                   bus_rdata,
  // nonvolatile configuration
  input  wire logic [7:0]                   config_base,
  input  wire cfs_pkg::cfs_term_s [11:0][2:0] sector_terms,
  input  wire logic [7:0]                   main_lock,
  input  wire logic [3:0]                   boot_lock,
  input  wire logic                         security_set,
  // logic array
  input  wire logic [2:0][7:0]              input_cells,
  output logic      [1:0][7:0]              output_cells,
  // port pins
  input  wire logic [3:0][7:0]              port_pin_in,
  output logic      [3:0][7:0]              port_pin_out,
  output logic      [3:0][7:0]              port_pin_oe,
  output logic      [3:0][3:0]              port_slew_fast,
  // selects and status
  output logic                              config_space_select,
  output logic      [7:0]                   main_sector_selects,
  output logic      [3:0]                   boot_sector_selects,
  output logic                              flash_ready_busy_pin,
  output logic      [7:0]                   address_page,
  output logic      [7:0]                   power_control_zero,
  output logic      [7:0]                   power_control_two
);
  import cfs_pkg::*;

  localparam logic [11:0] TMO_LAST = 12'(`CFS_BYTE_TIMEOUT_CYC - 1);

  cfs_state_s s_reg;
  cfs_state_s s_next;

  logic [11:0] sec_hit;
  logic [11:0] lock_all;
  logic [3:0]  sec_idx;
  logic        fl_any;
  logic        fl_main;
  logic        fl_wr;
  logic        fl_rd;
  logic        cmd_a1;
  logic        cmd_a2;
  logic [7:0]  mem_rdata;
  logic        mem_wr;
  logic        mem_erase;
  logic [7:0]  mem_waddr;
  logic [7:0]  cfg_rdata;
  logic [7:0]  ofs;

  assign lock_all = {boot_lock, main_lock};
  assign ofs      = bus.addr[7:0];

  // config window wins over any flash select
  assign config_space_select = (bus.addr[15:8] == config_base);

  // each select is the OR of three terms, gated by space and mapping
  always_comb begin
    logic [1:0] acc;
    logic [1:0] allow;
    allow   = 2'b00;
    acc     = {bus.psen, bus.rd | bus.wr};
    sec_hit = '0;
    for (int k = 0; k < 12; k++) begin
      allow = (k < 8) ? s_reg.vmap[1:0] : s_reg.vmap[3:2];
      for (int t = 0; t < 3; t++) begin
        if (((bus.addr & sector_terms[k][t].mask) == sector_terms[k][t].match) &&
            |(acc & sector_terms[k][t].space & allow)) begin
          sec_hit[k] = ~config_space_select;
        end
      end
    end
  end

  assign main_sector_selects = sec_hit[7:0];
  assign boot_sector_selects = sec_hit[11:8];

  always_comb begin
    sec_idx = 4'h0;
    for (int k = 11; k >= 0; k--) begin
      if (sec_hit[k]) begin
        sec_idx = 4'(k);
      end
    end
  end

  assign fl_any  = |sec_hit;
  assign fl_main = |sec_hit[7:0];
  assign fl_wr   = fl_any & bus.wr;
  assign fl_rd   = fl_any & (bus.rd | bus.psen);
  // only the low twelve address bits take part
  assign cmd_a1  = (bus.addr[11:0] == `CFS_ADR_UNLOCK_ONE);
  assign cmd_a2  = (bus.addr[11:0] == `CFS_ADR_UNLOCK_TWO);

  assign mem_wr    = (s_reg.fl == FL_BPROG) |
                     ((s_reg.fl == FL_BERASE) & s_reg.er_mask[s_reg.er_sec] & ~fl_wr);
  assign mem_erase = (s_reg.fl == FL_BERASE);
  assign mem_waddr = mem_erase ? {s_reg.er_sec, s_reg.er_off} : s_reg.pg_addr;

  cfs_flash_mem #(
    .WIDTH (8),
    .DEPTH (256)
  ) u_mem (
    .ref_clk  (ref_clk),
    .wr_en    (mem_wr),
    .wr_erase (mem_erase),
    .wr_addr  (mem_waddr),
    .wr_data  (s_reg.pg_data),
    .rd_addr  ({sec_idx, bus.addr[3:0]}),
    .rd_data  (mem_rdata)
  );

  // pin drivers
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      for (int i = 0; i < 8; i++) begin
        port_pin_out[p][i] = s_reg.dout[p][i];
        port_pin_oe[p][i]  = s_reg.dir[p][i];
        if (p < 2 && s_reg.fsel[p][i]) begin
          port_pin_out[p][i] = s_reg.addr_lat[8*p+i];
          port_pin_oe[p][i]  = 1'b1;
        end else if (i < 4 && s_reg.drv[p][i] && s_reg.dout[p][i]) begin
          // open drain: a one releases the pin rather than driving it
          port_pin_oe[p][i] = 1'b0;
        end
      end
      port_slew_fast[p] = s_reg.drv[p][7:4];
    end
  end

  // configuration reads
  always_comb begin
    case (ofs)
      `CFS_OFS_A_PIN_IN:      cfg_rdata = s_reg.sync2[0];
      `CFS_OFS_B_PIN_IN:      cfg_rdata = s_reg.sync2[1];
      `CFS_OFS_C_PIN_IN:      cfg_rdata = s_reg.sync2[2];
      `CFS_OFS_D_PIN_IN:      cfg_rdata = s_reg.sync2[3];
      `CFS_OFS_A_FUNC_SEL:    cfg_rdata = s_reg.fsel[0];
      `CFS_OFS_B_FUNC_SEL:    cfg_rdata = s_reg.fsel[1];
      `CFS_OFS_A_OUT_VAL:     cfg_rdata = s_reg.dout[0];
      `CFS_OFS_B_OUT_VAL:     cfg_rdata = s_reg.dout[1];
      `CFS_OFS_C_OUT_VAL:     cfg_rdata = s_reg.dout[2];
      `CFS_OFS_D_OUT_VAL:     cfg_rdata = s_reg.dout[3];
      `CFS_OFS_A_PIN_DIR:     cfg_rdata = s_reg.dir[0];
      `CFS_OFS_B_PIN_DIR:     cfg_rdata = s_reg.dir[1];
      `CFS_OFS_C_PIN_DIR:     cfg_rdata = s_reg.dir[2];
      `CFS_OFS_D_PIN_DIR:     cfg_rdata = s_reg.dir[3];
      `CFS_OFS_A_DRIVE:       cfg_rdata = s_reg.drv[0];
      `CFS_OFS_B_DRIVE:       cfg_rdata = s_reg.drv[1];
      `CFS_OFS_C_DRIVE:       cfg_rdata = s_reg.drv[2];
      `CFS_OFS_D_DRIVE:       cfg_rdata = s_reg.drv[3];
      `CFS_OFS_A_IN_CELLS:    cfg_rdata = input_cells[0];
      `CFS_OFS_B_IN_CELLS:    cfg_rdata = input_cells[1];
      `CFS_OFS_C_IN_CELLS:    cfg_rdata = input_cells[2];
      `CFS_OFS_A_DRV_EN:      cfg_rdata = port_pin_oe[0];
      `CFS_OFS_B_DRV_EN:      cfg_rdata = port_pin_oe[1];
      `CFS_OFS_C_DRV_EN:      cfg_rdata = port_pin_oe[2];
      `CFS_OFS_D_DRV_EN:      cfg_rdata = port_pin_oe[3];
      `CFS_OFS_CELLS_ONE:     cfg_rdata = s_reg.cells[0];
      `CFS_OFS_CELLS_TWO:     cfg_rdata = s_reg.cells[1];
      `CFS_OFS_CELLS_ONE_MSK: cfg_rdata = s_reg.cmask[0];
      `CFS_OFS_CELLS_TWO_MSK: cfg_rdata = s_reg.cmask[1];
      `CFS_OFS_POWER_ZERO:    cfg_rdata = s_reg.pm0;
      `CFS_OFS_POWER_TWO:     cfg_rdata = s_reg.pm2;
      `CFS_OFS_MAIN_LOCK:     cfg_rdata = main_lock;
      `CFS_OFS_BOOT_LOCK:     cfg_rdata = {security_set, 3'h0, boot_lock};
      `CFS_OFS_PAGE:          cfg_rdata = s_reg.page;
      `CFS_OFS_SPACE_MAP:     cfg_rdata = s_reg.vmap;
      default:                cfg_rdata = 8'h00;
    endcase
  end

  always_comb begin
    s_next          = s_reg;
    // first stage feeds only the second
    s_next.sync1    = port_pin_in;
    s_next.sync2    = s_reg.sync1;
    s_next.rsel_mem = 1'b0;
    if (bus.rd | bus.wr | bus.psen) begin
      s_next.addr_lat = bus.addr;
    end

    // register writes; read-only and unused offsets ignore them
    if (bus.wr && config_space_select) begin
      case (ofs)
        `CFS_OFS_A_FUNC_SEL:    s_next.fsel[0] = bus.wdata;
        `CFS_OFS_B_FUNC_SEL:    s_next.fsel[1] = bus.wdata;
        `CFS_OFS_A_OUT_VAL:     s_next.dout[0] = bus.wdata;
        `CFS_OFS_B_OUT_VAL:     s_next.dout[1] = bus.wdata;
        `CFS_OFS_C_OUT_VAL:     s_next.dout[2] = bus.wdata;
        `CFS_OFS_D_OUT_VAL:     s_next.dout[3] = bus.wdata;
        `CFS_OFS_A_PIN_DIR:     s_next.dir[0]  = bus.wdata;
        `CFS_OFS_B_PIN_DIR:     s_next.dir[1]  = bus.wdata;
        `CFS_OFS_C_PIN_DIR:     s_next.dir[2]  = bus.wdata;
        `CFS_OFS_D_PIN_DIR:     s_next.dir[3]  = bus.wdata;
        `CFS_OFS_A_DRIVE:       s_next.drv[0]  = bus.wdata;
        `CFS_OFS_B_DRIVE:       s_next.drv[1]  = bus.wdata;
        `CFS_OFS_C_DRIVE:       s_next.drv[2]  = bus.wdata;
        `CFS_OFS_D_DRIVE:       s_next.drv[3]  = bus.wdata;
        `CFS_OFS_CELLS_ONE: begin
          s_next.cells[0] = (s_reg.cells[0] & s_reg.cmask[0]) |
                            (bus.wdata & ~s_reg.cmask[0]);
        end
        `CFS_OFS_CELLS_TWO: begin
          s_next.cells[1] = (s_reg.cells[1] & s_reg.cmask[1]) |
                            (bus.wdata & ~s_reg.cmask[1]);
        end
        `CFS_OFS_CELLS_ONE_MSK: s_next.cmask[0] = bus.wdata;
        `CFS_OFS_CELLS_TWO_MSK: s_next.cmask[1] = bus.wdata;
        `CFS_OFS_POWER_ZERO:    s_next.pm0      = bus.wdata;
        `CFS_OFS_POWER_TWO:     s_next.pm2      = bus.wdata;
        `CFS_OFS_PAGE:          s_next.page     = bus.wdata;
        `CFS_OFS_SPACE_MAP:     s_next.vmap     = bus.wdata;
        default: begin
        end
      endcase
    end

    // read answer, one cycle after the strobe
    if ((bus.rd | bus.psen) && config_space_select) begin
      s_next.rdata = cfg_rdata;
    end else if (fl_rd) begin
      if (s_reg.fl == FL_BPROG || s_reg.fl == FL_BERASE) begin
        // status poll: bit 6 toggles while busy
        s_next.toggle = ~s_reg.toggle;
        s_next.rdata  = {1'b0, s_reg.toggle, 6'h00};
      end else if (s_reg.fl == FL_PROT) begin
        s_next.rdata = (bus.addr[1:0] == 2'h2) ? {7'h00, lock_all[sec_idx]} : 8'h00;
      end else begin
        s_next.rsel_mem = 1'b1;
      end
    end

    // command sequencer; byte timer restarts on each flash write
    if (fl_wr) begin
      s_next.tmo = 12'h000;
    end else begin
      s_next.tmo = s_reg.tmo + 12'h001;
    end
    case (s_reg.fl)
      FL_READ: begin
        s_next.tmo = 12'h000;
        if (fl_wr && bus.wdata == `CFS_CMD_UNLOCK_ONE && cmd_a1) begin
          s_next.fl = FL_UNL1;
        end
      end
      FL_UNL1: begin
        if (fl_wr) begin
          s_next.fl = (bus.wdata == `CFS_CMD_UNLOCK_TWO && cmd_a2) ? FL_UNL2 : FL_READ;
        end
      end
      FL_UNL2: begin
        if (fl_wr) begin
          s_next.fl = FL_READ;
          if (cmd_a1) begin
            case (bus.wdata)
              `CFS_CMD_PROT_READ:   s_next.fl = FL_PROT;
              `CFS_CMD_PROGRAM:     s_next.fl = FL_PROG;
              `CFS_CMD_ERASE_SETUP: s_next.fl = FL_ERS0;
              default:              s_next.fl = FL_READ;
            endcase
          end
        end
      end
      FL_ERS0: begin
        if (fl_wr) begin
          s_next.fl = (bus.wdata == `CFS_CMD_UNLOCK_ONE && cmd_a1) ? FL_ERS1 : FL_READ;
        end
      end
      FL_ERS1: begin
        if (fl_wr) begin
          s_next.fl = (bus.wdata == `CFS_CMD_UNLOCK_TWO && cmd_a2) ? FL_ERS2 : FL_READ;
        end
      end
      FL_ERS2: begin
        if (fl_wr) begin
          s_next.er_sec  = 4'h0;
          s_next.er_off  = 4'h0;
          s_next.er_mask = 12'h000;
          if (bus.wdata == `CFS_CMD_SECTOR_ERASE) begin
            s_next.er_mask = sec_hit & ~lock_all;
          end else if (bus.wdata == `CFS_CMD_BULK_ERASE && cmd_a1) begin
            s_next.er_mask = (fl_main ? 12'h0ff : 12'hf00) & ~lock_all;
          end
          s_next.fl = |s_next.er_mask ? FL_BERASE : FL_READ;
        end
      end
      FL_PROG: begin
        if (fl_wr) begin
          s_next.pg_addr = {sec_idx, bus.addr[3:0]};
          s_next.pg_data = bus.wdata;
          s_next.fl      = lock_all[sec_idx] ? FL_READ : FL_BPROG;
        end
      end
      FL_PROT: begin
        s_next.tmo = 12'h000;
        if (fl_wr && bus.wdata == `CFS_CMD_RESET) begin
          s_next.fl = FL_READ;
        end
      end
      FL_BPROG: begin
        s_next.tmo = 12'h000;
        s_next.fl  = FL_READ;
      end
      FL_BERASE: begin
        s_next.tmo = 12'h000;
        if (fl_wr && bus.wdata == `CFS_CMD_SUSPEND) begin
          s_next.fl = FL_SUSP;
        end else if (s_reg.er_mask == 12'h000) begin
          s_next.fl = FL_READ;
        end else if (!s_reg.er_mask[s_reg.er_sec] || s_reg.er_off == 4'hf) begin
          if (s_reg.er_mask[s_reg.er_sec]) begin
            s_next.er_mask[s_reg.er_sec] = 1'b0;
          end
          s_next.er_off = 4'h0;
          s_next.er_sec = (s_reg.er_sec == 4'hb) ? 4'h0 : s_reg.er_sec + 4'h1;
        end else begin
          s_next.er_off = s_reg.er_off + 4'h1;
        end
      end
      FL_SUSP: begin
        // plain reads of other sectors are served meanwhile
        s_next.tmo = 12'h000;
        if (fl_wr && bus.wdata == `CFS_CMD_SECTOR_ERASE) begin
          s_next.fl = FL_BERASE;
        end
      end
      default: begin
        s_next.fl = FL_READ;
      end
    endcase
    if (s_reg.tmo == TMO_LAST && !fl_wr) begin
      s_next.fl  = FL_READ;
      s_next.tmo = 12'h000;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_reg      <= '0;
      s_reg.fl   <= FL_READ;
      s_reg.vmap <= `CFS_RST_SPACE_MAP;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus_rdata            = s_reg.rsel_mem ? mem_rdata : s_reg.rdata;
  assign flash_ready_busy_pin = ~((s_reg.fl == FL_BPROG) | (s_reg.fl == FL_BERASE));
  assign output_cells         = s_reg.cells;
  assign address_page         = s_reg.page;
  assign power_control_zero   = s_reg.pm0;
  assign power_control_two    = s_reg.pm2;
endmodule : cfs_top

// ---- rtl/cfs_regs.svh ----
// register offsets, reset values and timing counts of the configuration space
// assumes 25 MHz ref_clk and an 8-bit offset into the 256-byte window
`ifndef CFS_REGS_SVH
`define CFS_REGS_SVH
`define CFS_OFS_A_PIN_IN      8'h00
`define CFS_OFS_B_PIN_IN      8'h01
`define CFS_OFS_A_FUNC_SEL    8'h02
`define CFS_OFS_B_FUNC_SEL    8'h03
`define CFS_OFS_A_OUT_VAL     8'h04
`define CFS_OFS_B_OUT_VAL     8'h05
`define CFS_OFS_A_PIN_DIR     8'h06
`define CFS_OFS_B_PIN_DIR     8'h07
`define CFS_OFS_A_DRIVE       8'h08
`define CFS_OFS_B_DRIVE       8'h09
`define CFS_OFS_A_IN_CELLS    8'h0a
`define CFS_OFS_B_IN_CELLS    8'h0b
`define CFS_OFS_A_DRV_EN      8'h0c
`define CFS_OFS_B_DRV_EN      8'h0d
`define CFS_OFS_C_PIN_IN      8'h10
`define CFS_OFS_D_PIN_IN      8'h11
`define CFS_OFS_C_OUT_VAL     8'h12
`define CFS_OFS_D_OUT_VAL     8'h13
`define CFS_OFS_C_PIN_DIR     8'h14
`define CFS_OFS_D_PIN_DIR     8'h15
`define CFS_OFS_C_DRIVE       8'h16
`define CFS_OFS_D_DRIVE       8'h17
`define CFS_OFS_C_IN_CELLS    8'h18
`define CFS_OFS_C_DRV_EN      8'h1a
`define CFS_OFS_D_DRV_EN      8'h1b
`define CFS_OFS_CELLS_ONE     8'h20
`define CFS_OFS_CELLS_TWO     8'h21
`define CFS_OFS_CELLS_ONE_MSK 8'h22
`define CFS_OFS_CELLS_TWO_MSK 8'h23
`define CFS_OFS_POWER_ZERO    8'hb0
`define CFS_OFS_POWER_TWO     8'hb4
`define CFS_OFS_MAIN_LOCK     8'hc0
`define CFS_OFS_BOOT_LOCK     8'hc2
`define CFS_OFS_PAGE          8'he0
`define CFS_OFS_SPACE_MAP     8'he2
`define CFS_RST_BYTE          8'h00
`define CFS_RST_SPACE_MAP     8'h0f
`define CFS_CMD_UNLOCK_ONE    8'haa
`define CFS_CMD_UNLOCK_TWO    8'h55
`define CFS_CMD_PROT_READ     8'h90
`define CFS_CMD_PROGRAM       8'ha0
`define CFS_CMD_ERASE_SETUP   8'h80
`define CFS_CMD_SECTOR_ERASE  8'h30
`define CFS_CMD_BULK_ERASE    8'h10
`define CFS_CMD_SUSPEND       8'hb0
`define CFS_CMD_RESET         8'hf0
`define CFS_ADR_UNLOCK_ONE    12'h555
`define CFS_ADR_UNLOCK_TWO    12'haaa
`define CFS_CLK_MHZ           25
`define CFS_BYTE_TIMEOUT_US   80
`define CFS_BYTE_TIMEOUT_CYC  (`CFS_BYTE_TIMEOUT_US * `CFS_CLK_MHZ)
`endif

// ---- rtl/cfs_pkg.sv ----
// types shared by the configuration space and flash select block
// assumes the constants of cfs_regs.svh
package cfs_pkg;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
    logic        psen;
  } cfs_bus_s;

  // one product term: space bit 0 data, bit 1 program
  typedef struct packed {
    logic [15:0] mask;
    logic [15:0] match;
    logic [1:0]  space;
  } cfs_term_s;

  typedef enum logic [10:0] {
    FL_READ   = 11'h001,
    FL_UNL1   = 11'h002,
    FL_UNL2   = 11'h004,
    FL_ERS0   = 11'h008,
    FL_ERS1   = 11'h010,
    FL_ERS2   = 11'h020,
    FL_PROG   = 11'h040,
    FL_PROT   = 11'h080,
    FL_BPROG  = 11'h100,
    FL_BERASE = 11'h200,
    FL_SUSP   = 11'h400
  } cfs_fl_e;

  typedef struct packed {
    logic [3:0][7:0] sync1;
    logic [3:0][7:0] sync2;
    logic [3:0][7:0] dout;
    logic [3:0][7:0] dir;
    logic [3:0][7:0] drv;
    logic [1:0][7:0] fsel;
    logic [1:0][7:0] cells;
    logic [1:0][7:0] cmask;
    logic [7:0]      pm0;
    logic [7:0]      pm2;
    logic [7:0]      page;
    logic [7:0]      vmap;
    logic [15:0]     addr_lat;
    logic [7:0]      rdata;
    logic            rsel_mem;
    cfs_fl_e         fl;
    logic [11:0]     tmo;
    logic [11:0]     er_mask;
    logic [3:0]      er_sec;
    logic [3:0]      er_off;
    logic [7:0]      pg_addr;
    logic [7:0]      pg_data;
    logic            toggle;
  } cfs_state_s;
endpackage : cfs_pkg

// ---- rtl/cfs_flash_mem.sv ----
// small flash array model: 12 sectors of 16 bytes, registered read
// assumes the owner never programs and erases in the same cycle
`timescale 1ns/1ps
module cfs_flash_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 256
) (
  // clock
  input  wire logic             ref_clk,
  // write side
  input  wire logic             wr_en,
  input  wire logic             wr_erase,
  input  wire logic [7:0]       wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // read side
  input  wire logic [7:0]       rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // programming only clears bits; only erase brings them back to one
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_erase ? {WIDTH{1'b1}} : (mem[wr_addr] & wr_data);
    end
    rd_data <= mem[rd_addr];
  end
endmodule : cfs_flash_mem

// ---- tb/cfs_checker.sv ----
// assertions on the configuration space bus, selects and flash status
// assumes one clock with synchronous reset; bound to cfs_top
`timescale 1ns/1ps
module cfs_checker (
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              reset,
  // bus
  input wire cfs_pkg::cfs_bus_s bus,
  input wire logic [7:0]        bus_rdata,
  // configuration and live state
  input wire logic [7:0]        config_base,
  input wire logic [7:0]        main_lock,
  input wire logic [3:0][7:0]   port_pin_oe,
  input wire logic [1:0][7:0]   output_cells,
  // selects and status
  input wire logic              config_space_select,
  input wire logic [7:0]        main_sector_selects,
  input wire logic [3:0]        boot_sector_selects,
  input wire logic              flash_ready_busy_pin,
  input wire logic [7:0]        address_page
);
  import cfs_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire       cfg_rd = bus.rd && config_space_select;
  wire       cfg_wr = bus.wr && config_space_select;
  wire [7:0] ofs    = bus.addr[7:0];
  sequence s_unlock;
    bus.wr && bus.wdata == 8'haa && bus.addr[11:0] == 12'h555
    ##2 bus.wr && bus.wdata == 8'h55 && bus.addr[11:0] == 12'haaa;
  endsequence
  // writes are two cycles apart, as the master model issues them
  sequence s_prog;
    s_unlock ##2 bus.wr && bus.wdata == 8'ha0 && bus.addr[11:0] == 12'h555 ##2 bus.wr;
  endsequence
  a_window_decode: assert property (
    config_space_select == (bus.addr[15:8] == config_base)) else $error("window decode");
  a_select_excl: assert property (
    config_space_select |-> main_sector_selects == 8'h00 && boot_sector_selects == 4'h0)
    else $error("sector select inside window");
  a_cells_read: assert property (
    cfg_rd && ofs == 8'h20 |=> bus_rdata == $past(output_cells[0])) else $error("cells read");
  a_lock_read: assert property (
    cfg_rd && ofs == 8'hc0 |=> bus_rdata == $past(main_lock)) else $error("lock read");
  a_write_quiet: assert property (
    cfg_wr && ofs == 8'hc0 |=> $stable(bus_rdata)) else $error("write moved read data");
  a_enable_read: assert property (
    cfg_rd && ofs == 8'h0c |=> bus_rdata == $past(port_pin_oe[0])) else $error("enable read");
  a_unused_zero: assert property (
    cfg_rd && ofs == 8'h30 |=> bus_rdata == 8'h00) else $error("unused offset not zero");
  a_page_write: assert property (
    cfg_wr && ofs == 8'he0 |=> address_page == $past(bus.wdata)) else $error("page write");
  a_prog_busy: assert property (
    s_prog ##0 (|(main_sector_selects & ~main_lock)) |=> !flash_ready_busy_pin)
    else $error("program did not go busy");
  a_lock_guard: assert property (
    s_prog ##0 (|(main_sector_selects & main_lock)) |=> flash_ready_busy_pin)
    else $error("locked sector went busy");
  a_busy_bound: assert property (
    $fell(flash_ready_busy_pin) |-> ##[1:300] flash_ready_busy_pin) else $error("busy hung");
endmodule : cfs_checker

bind cfs_top cfs_checker u_chk (.ref_clk, .reset, .bus, .bus_rdata, .config_base, .main_lock,
  .port_pin_oe, .output_cells, .config_space_select, .main_sector_selects,
  .boot_sector_selects, .flash_ready_busy_pin, .address_page);

// ---- tb/cfs_master.sv ----
// processor bus master model: one-cycle strobes, flash command openers
// assumes the bench calls its tasks one after another
`timescale 1ns/1ps
module cfs_master (
  // clock
  input wire logic         ref_clk,
  // bus
  output cfs_pkg::cfs_bus_s bus,
  input wire logic [7:0]   bus_rdata
);
  import cfs_pkg::*;
  initial bus = '0;
  // released address and data are inverted so stale values never pass
  task automatic xfer(input logic [15:0] a, input logic [7:0] d, input logic w,
                      output logic [7:0] q);
    @(negedge ref_clk);
    bus = '{a, d, !w, w, 1'b0};
    @(negedge ref_clk);
    q = bus_rdata;
    bus = '{~a, ~d, 1'b0, 1'b0, 1'b0};
  endtask : xfer
  // flash is changed only by unlocked commands
  task automatic cmd(input logic [15:0] a, input logic [7:0] c);
    logic [7:0] q;
    xfer({a[15:12], 12'h555}, 8'haa, 1'b1, q);
    xfer({a[15:12], 12'haaa}, 8'h55, 1'b1, q);
    xfer({a[15:12], 12'h555}, c, 1'b1, q);
  endtask : cmd
endmodule : cfs_master

// ---- tb/cfs_top_bench.sv ----
// bench: register and flash scenarios through the master model
// assumes cfs_top, cfs_master and the checker are compiled first
`timescale 1ns/1ps
module cfs_top_bench;
  import cfs_pkg::*;
  logic                  ref_clk = 1'b0;
  logic                  reset = 1'b1;
  cfs_bus_s              bus;
  logic [7:0]            bus_rdata, address_page, power_control_zero, power_control_two, q;
  logic [7:0]            config_base = 8'h80;
  logic [7:0]            main_lock = 8'h20;
  logic [3:0]            boot_lock = 4'h2;
  logic                  security_set = 1'b1;
  cfs_term_s [11:0][2:0] sector_terms;
  logic [2:0][7:0]       input_cells = 24'h0c0b0a;
  logic [1:0][7:0]       output_cells;
  logic [3:0][7:0]       port_pin_in = 32'h44332211, port_pin_out, port_pin_oe;
  logic [3:0][3:0]       port_slew_fast;
  logic                  config_space_select, flash_ready_busy_pin;
  logic [7:0]            main_sector_selects;
  logic [3:0]            boot_sector_selects;
  wire  [6:0][7:0]       ro_val = {input_cells, port_pin_in};
  logic [7:0] ro_ofs[7] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h0a, 8'h0b, 8'h18};
  logic [7:0] rw_ofs[20] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h12,
    8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h22, 8'h23, 8'hb0, 8'hb4, 8'he0, 8'he2};
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  always #20 ref_clk = ~ref_clk;
  cfs_top DUT (.ref_clk, .reset, .bus, .bus_rdata, .config_base, .sector_terms, .main_lock,
    .boot_lock, .security_set, .input_cells, .output_cells, .port_pin_in, .port_pin_out,
    .port_pin_oe, .port_slew_fast, .config_space_select, .main_sector_selects,
    .boot_sector_selects, .flash_ready_busy_pin, .address_page, .power_control_zero,
    .power_control_two);
  cfs_master mst (.ref_clk, .bus, .bus_rdata);
  // selects only stand while a strobe does, so keep the last strobed value
  logic [7:0] main_seen = 8'h00;
  logic [3:0] boot_seen = 4'h0;
  always @(posedge ref_clk) begin
    if (bus.rd | bus.wr | bus.psen) begin
      main_seen <= main_sector_selects;
      boot_seen <= boot_sector_selects;
    end
  end
  task automatic check(input string n, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    mst.xfer(a, d, 1'b1, q);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input string n);
    mst.xfer(a, 8'h00, 1'b0, q);
    check(n, q, e);
  endtask : rd
  task automatic wait_ready;
    for (int n = 0; n < 400 && flash_ready_busy_pin !== 1'b1; n++) @(negedge ref_clk);
    check("ready", flash_ready_busy_pin, 1'b1);
  endtask : wait_ready
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end
  // main sectors at 0x0000-0x7fff, boot sectors at 0x9000-0xcfff
  initial begin
    for (int i = 0; i < 12; i++) begin
      sector_terms[i][0] = '{16'hf000, {i[3:0] + ((i < 8) ? 4'h0 : 4'h1), 12'h000}, 2'b11};
      sector_terms[i][1] = '{16'h0000, 16'hffff, 2'b11};
      sector_terms[i][2] = '{16'h0000, 16'hffff, 2'b11};
    end
  end
  initial begin
    repeat (20) @(negedge ref_clk);
    reset = 1'b0;
    foreach (rw_ofs[i]) rd({8'h80, rw_ofs[i]}, (rw_ofs[i] == 8'he2) ? 8'h0f : 8'h00, "reset");
    foreach (rw_ofs[i]) wr({8'h80, rw_ofs[i]}, rw_ofs[i] ^ 8'h5a);
    foreach (rw_ofs[i]) rd({8'h80, rw_ofs[i]}, rw_ofs[i] ^ 8'h5a, "read back");
    foreach (ro_ofs[i]) rd({8'h80, ro_ofs[i]}, ro_val[i], "pin input");
    check("page", address_page, 8'hba);
    check("slew", {4'h0, port_slew_fast[0]}, 8'h05);
    // bits 3,4,6 show the address latched by the read of 0x18
    check("pin out", port_pin_out[0], 8'h1e);
    check("power zero", power_control_zero, 8'hea);
    check("power two", power_control_two, 8'hee);
    check("pin oe", port_pin_oe[0], 8'h5c);
    rd(16'h800c, 8'h5c, "enable state");
    wr(16'h8020, 8'hff);
    rd(16'h8020, 8'h87, "output cells");
    wr(16'h80c0, 8'hff);
    rd(16'h80c0, 8'h20, "main lock");
    wr(16'h8030, 8'hff);
    rd(16'h8030, 8'h00, "unused");
    wr(16'h8002, 8'hff);
    check("address out", port_pin_out[0], 8'h02);
    // open both flash arrays to data and program space again
    wr(16'h80e2, 8'h0f);
    mst.cmd(16'h1000, 8'h80);
    mst.cmd(16'h1000, 8'h30);
    check("erase busy", flash_ready_busy_pin, 1'b0);
    wr(16'h1000, 8'hb0);
    check("suspended", flash_ready_busy_pin, 1'b1);
    wr(16'h1000, 8'h30);
    check("resumed", flash_ready_busy_pin, 1'b0);
    wait_ready();
    rd(16'h1003, 8'hff, "erased");
    mst.cmd(16'h1000, 8'ha0);
    wr(16'h1003, 8'h3c);
    check("program busy", flash_ready_busy_pin, 1'b0);
    wait_ready();
    rd(16'h1003, 8'h3c, "programmed");
    mst.cmd(16'h1000, 8'h77);
    wr(16'h1003, 8'h00);
    rd(16'h1003, 8'h3c, "bad command");
    mst.cmd(16'h5000, 8'ha0);
    wr(16'h5003, 8'h00);
    check("locked", flash_ready_busy_pin, 1'b1);
    check("main select", main_seen, 8'h20);
    mst.cmd(16'ha000, 8'h90);
    rd(16'ha002, 8'h01, "boot lock");
    check("boot select", {4'h0, boot_seen}, 8'h02);
    wr(16'ha000, 8'hf0);
    summarize();
  end
endmodule : cfs_top_bench
